// ===== src/txs_regs.sv
// transmit outcome, byte count, collision tally and receive page registers
//
// Overview of operation
// - late collision during a frame sets outcome bit 7.
// - giving up after excessive collisions sets outcome bit 3.
// - any collision during the frame sets outcome bit 2.
// - error-free send sets bit 0; bits 6:4 and 1 read zero; resets to 00h.
// - tally shows this attempt's collisions in 3:0, upper bits zero, resets 00h.
// - an attempt with no collision leaves tally zero, and collided clear unless an earlier attempt of the frame collided.
// - an excessive-collision abort sets gave-up and forces the tally to zero.
// - setting the send bit in the command register clears the tally.
// - receive page pointer holds next frame's first page, resets 4Dh.
// - a receive error restores the receive DMA pointer from the page pointer.
`timescale 1ns/10ps
`default_nettype none
module txs_regs import txs_pkg::*; #(
    parameter int LW = LEN_W,
    parameter int TW = TALLY_W
) (
    input  wire logic              clk,
    input  wire logic              rst,
    // host bus pins, asynchronous to clk
    input  wire logic              hb_cs_n,
    input  wire logic              hb_rd_n,
    input  wire logic              hb_wr_n,
    input  wire logic [ADDR_W-1:0] hb_addr,
    input  wire logic [DATA_W-1:0] hb_data_in,
    output logic      [DATA_W-1:0] hb_data_out,
    output logic                   hb_data_oe,
    // transmit engine
    input  wire txs_tx_ev_s        tx_ev,
    output logic                   tx_start,
    output logic      [LW-1:0]     tx_len,
    // receive engine
    input  wire logic              rx_page_load,
    input  wire logic [DATA_W-1:0] rx_page_value,
    input  wire logic              rx_error,
    output logic                   rx_restore,
    output logic      [DATA_W-1:0] rx_restore_page
);

    localparam int BUS_W = $bits(txs_bus_s);
    localparam txs_bus_s BUS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                                      addr: '0, data: '0};

    txs_bus_s          bus_raw;
    txs_bus_s          bus_s;
    logic              wr_act;
    logic              wr_act_d_r;
    logic              wr_pulse;
    logic              rd_act;
    logic [ADDR_W-1:0] wr_addr_r;
    logic [DATA_W-1:0] wr_data_r;
    logic [1:0]        page;

    logic [DATA_W-1:0] command_reg_r;
    logic [DATA_W-1:0] tx_outcome_reg_r;
    logic [DATA_W-1:0] tx_len_low_r;
    logic [DATA_W-1:0] tx_len_high_r;
    logic [DATA_W-1:0] rx_write_page_ptr_r;
    logic [TW-1:0]     tx_retry_tally;
    logic              col_seen_r;
    logic              send_frame_cmd;
    logic [DATA_W-1:0] rd_data_nxt;
    logic [DATA_W-1:0] tx_outcome_reg_nxt;
    logic              hit_command;
    logic              hit_len_low;
    logic              hit_len_high;
    logic              hit_rx_page;

    // pin inputs cross into the clock domain before any decode
    assign bus_raw = '{cs_n: hb_cs_n, rd_n: hb_rd_n, wr_n: hb_wr_n,
                       addr: hb_addr, data: hb_data_in};

    txs_sync #(
        .W       (BUS_W),
        .RST_VAL (BUS_IDLE)
    ) u_bus_sync (
        .clk  (clk),
        .rst  (rst),
        .din  (bus_raw),
        .dout (bus_s)
    );

    assign wr_act = !bus_s.cs_n && !bus_s.wr_n;
    assign rd_act = !bus_s.cs_n && !bus_s.rd_n;

    // a write commits on the trailing edge of the strobe, when the data is known settled
    assign wr_pulse = wr_act_d_r && !wr_act;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_act_d_r <= 1'b0;
        end else begin
            wr_act_d_r <= wr_act;
        end
    end

    // address and data are taken every cycle the strobe is seen, so the last
    // settled value before release is the one that commits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_addr_r <= '0;
            wr_data_r <= '0;
        end else if (wr_act) begin
            wr_addr_r <= bus_s.addr;
            wr_data_r <= bus_s.data;
        end
    end

    assign page = {command_reg_r[CMD_PAGE_HI], command_reg_r[CMD_PAGE_LO]};

    // write decode, one hit per register; the command register answers on every
    // page, otherwise a host parked on page 2 or 3 could never get back
    always_comb begin
        hit_command  = 1'b0;
        hit_len_low  = 1'b0;
        hit_len_high = 1'b0;
        hit_rx_page  = 1'b0;
        if (wr_pulse) begin
            if (wr_addr_r == OFS_COMMAND) begin
                hit_command = 1'b1;
            end else begin
                case (page)
                    PAGE_0: begin
                        hit_len_low  = (wr_addr_r == OFS_TX_LEN_LOW);
                        hit_len_high = (wr_addr_r == OFS_TX_LEN_HIGH);
                    end
                    PAGE_1: begin
                        hit_rx_page = (wr_addr_r == OFS_RX_PAGE);
                    end
                    default: begin
                        // pages 2 and 3 hold nothing of this slice; writes there are dropped
                        hit_rx_page = 1'b0;
                    end
                endcase
            end
        end
    end

    // send request from the host; the page does not matter for the command register
    assign send_frame_cmd = hit_command && wr_data_r[CMD_SEND_BIT];

    // command register: the send bit drops when the engine finishes the frame
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            command_reg_r <= COMMAND_RST;
        end else begin
            if (hit_command) begin
                command_reg_r <= wr_data_r;
            end else if (tx_ev.done) begin
                command_reg_r[CMD_SEND_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_start <= 1'b0;
        end else begin
            tx_start <= send_frame_cmd;
        end
    end

    // frame length registers, write-only from the host; the two bytes load
    // independently, so the host may write them in either order
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_len_low_r <= TX_LEN_BYTE_RST;
        end else if (hit_len_low) begin
            tx_len_low_r <= wr_data_r;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_len_high_r <= TX_LEN_BYTE_RST;
        end else if (hit_len_high) begin
            tx_len_high_r <= wr_data_r;
        end
    end

    assign tx_len = LW'({tx_len_high_r, tx_len_low_r});

    // remembers whether any attempt of this frame met a collision
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            col_seen_r <= 1'b0;
        end else begin
            if (tx_ev.collision) begin
                col_seen_r <= 1'b1;
            end else if (send_frame_cmd || tx_ev.done) begin
                col_seen_r <= 1'b0;
            end
        end
    end

    // the finished frame's flags gathered into one word, reserved bits zero; a
    // collision in the done cycle still counts, so no event of the frame is lost
    always_comb begin
        tx_outcome_reg_nxt                  = TX_OUTCOME_RST;
        tx_outcome_reg_nxt[OUT_LATE_BIT]    = tx_ev.late;
        tx_outcome_reg_nxt[OUT_GAVE_UP_BIT] = tx_ev.excess;
        tx_outcome_reg_nxt[OUT_COLL_BIT]    = col_seen_r || tx_ev.collision;
        tx_outcome_reg_nxt[OUT_OK_BIT]      = tx_ev.ok && !tx_ev.late
                                              && !tx_ev.excess;
    end

    // outcome flags load as one word at frame end and hold until the next start
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_outcome_reg_r <= TX_OUTCOME_RST;
        end else if (tx_ev.done) begin
            tx_outcome_reg_r <= tx_outcome_reg_nxt;
        end else if (send_frame_cmd) begin
            tx_outcome_reg_r <= TX_OUTCOME_RST;
        end
    end

    // the tally counts collisions of one attempt, the collided flag those of the
    // whole frame, so after a retry the two may disagree; that is intended
    txs_tally #(
        .W (TW)
    ) u_tally (
        .clk           (clk),
        .rst           (rst),
        .clear         (send_frame_cmd),
        .attempt_start (tx_ev.attempt_start),
        .collision     (tx_ev.collision),
        .abort         (tx_ev.done && tx_ev.excess),
        .tally         (tx_retry_tally)
    );

    // receive page pointer: the receive engine's advance takes precedence
    // over a host write, since software should not rewrite it while running
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_write_page_ptr_r <= RX_PAGE_RST;
        end else if (rx_page_load) begin
            rx_write_page_ptr_r <= rx_page_value;
        end else if (hit_rx_page) begin
            rx_write_page_ptr_r <= wr_data_r;
        end
    end

    // on a receive error the DMA pointer is rewound to the saved page
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_restore <= 1'b0;
        end else begin
            rx_restore <= rx_error;
        end
    end

    // the page is held after the pulse so the receive engine may take it late
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_restore_page <= RX_PAGE_RST;
        end else if (rx_error) begin
            rx_restore_page <= rx_write_page_ptr_r;
        end
    end

    // read decode; unmapped and write-only locations read as zero
    always_comb begin
        rd_data_nxt = READ_ZERO;
        if (bus_s.addr == OFS_COMMAND) begin
            rd_data_nxt = command_reg_r;
        end else begin
            case (page)
                PAGE_0: begin
                    if (bus_s.addr == OFS_TX_OUTCOME) begin
                        rd_data_nxt = tx_outcome_reg_r;
                    end else if (bus_s.addr == OFS_TX_TALLY) begin
                        rd_data_nxt = DATA_W'(tx_retry_tally);
                    end
                end
                PAGE_1: begin
                    if (bus_s.addr == OFS_RX_PAGE) begin
                        rd_data_nxt = rx_write_page_ptr_r;
                    end
                end
                default: begin
                    rd_data_nxt = READ_ZERO;
                end
            endcase
        end
    end

    // read data is registered; the enable follows the synchronised strobes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hb_data_out <= READ_ZERO;
        end else begin
            hb_data_out <= rd_data_nxt;
        end
    end

    // the device keeps driving the data pins for two cycles after the host
    // lets go of the strobe; the host must wait that out before turning the bus
    assign hb_data_oe = rd_act;

endmodule
`default_nettype wire

// ===== src/txs_pkg.sv
// package: offsets, field positions, reset values and carriers of the transmit status slice
package txs_pkg;

    localparam int          DATA_W          = 8;
    localparam int          ADDR_W          = 4;
    localparam int          LEN_W           = 16;
    localparam int          TALLY_W         = 4;
    localparam int          SYNC_STAGES     = 2;

    // register offsets within a page
    localparam logic [3:0]  OFS_COMMAND     = 4'h0;
    localparam logic [3:0]  OFS_TX_OUTCOME  = 4'h4;
    localparam logic [3:0]  OFS_TX_LEN_LOW  = 4'h5;
    localparam logic [3:0]  OFS_TX_TALLY    = 4'h5;
    localparam logic [3:0]  OFS_TX_LEN_HIGH = 4'h6;
    localparam logic [3:0]  OFS_RX_PAGE     = 4'h7;

    // register pages selected by the command register
    localparam logic [1:0]  PAGE_0          = 2'h0;
    localparam logic [1:0]  PAGE_1          = 2'h1;

    // command register fields
    localparam int          CMD_PAGE_HI     = 7;
    localparam int          CMD_PAGE_LO     = 6;
    localparam int          CMD_SEND_BIT    = 2;

    // transmit outcome fields
    localparam int          OUT_LATE_BIT    = 7;
    localparam int          OUT_GAVE_UP_BIT = 3;
    localparam int          OUT_COLL_BIT    = 2;
    localparam int          OUT_OK_BIT      = 0;

    // reset values
    localparam logic [7:0]  COMMAND_RST     = 8'h21;
    localparam logic [7:0]  TX_OUTCOME_RST  = 8'h00;
    localparam logic [7:0]  TX_TALLY_RST    = 8'h00;
    localparam logic [7:0]  RX_PAGE_RST     = 8'h4d;
    localparam logic [7:0]  TX_LEN_BYTE_RST = 8'h00;
    localparam logic [7:0]  READ_ZERO       = 8'h00;

    // events from the transmit engine, all one-cycle pulses except the qualifiers
    typedef struct packed {
        logic attempt_start;
        logic collision;
        logic done;
        logic ok;
        logic late;
        logic excess;
    } txs_tx_ev_s;

    // host bus pins after synchronisation
    typedef struct packed {
        logic              cs_n;
        logic              rd_n;
        logic              wr_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } txs_bus_s;

endpackage

// ===== src/txs_sync.sv
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none
module txs_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_r;

    // the first stage feeds only the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= RST_VAL;
            dout   <= RST_VAL;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ===== src/txs_tally.sv
// per-attempt collision tally
`timescale 1ns/10ps
`default_nettype none
module txs_tally import txs_pkg::*; #(
    parameter int W = TALLY_W
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         clear,
    input  wire logic         attempt_start,
    input  wire logic         collision,
    input  wire logic         abort,
    output logic      [W-1:0] tally
);
    logic [W-1:0] tally_nxt;

    always_comb begin
        tally_nxt = tally;
        if (clear || attempt_start) begin
            tally_nxt = '0;
        end
        // a collision in the clearing cycle still counts; saturate at the top
        if (collision && (tally_nxt != '1)) begin
            tally_nxt = tally_nxt + W'(1);
        end
        if (abort) begin
            tally_nxt = '0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tally <= TX_TALLY_RST[W-1:0];
        end else begin
            tally <= tally_nxt;
        end
    end
endmodule
`default_nettype wire

// ===== tb/txs_regs_props.sv
// checker: port timing relations of the transmit status slice
`timescale 1ns/10ps
`default_nettype none
module txs_regs_props import txs_pkg::*; #(
    parameter int LW = LEN_W
) (
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              hb_cs_n,
    input wire logic              hb_rd_n,
    input wire logic              hb_wr_n,
    input wire logic              hb_data_oe,
    input wire logic              tx_start,
    input wire logic [LW-1:0]     tx_len,
    input wire logic              rx_page_load,
    input wire logic [DATA_W-1:0] rx_page_value,
    input wire logic              rx_error,
    input wire logic              rx_restore,
    input wire logic [DATA_W-1:0] rx_restore_page
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic       rd_act;
    logic [7:0] wr_age_r;
    assign rd_act = !hb_cs_n && !hb_rd_n;
    // cycles since a write strobe was last seen at the pins; saturates
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_age_r <= 8'hff;
        end else if (!hb_cs_n && !hb_wr_n) begin
            wr_age_r <= 8'h00;
        end else if (wr_age_r != 8'hff) begin
            wr_age_r <= wr_age_r + 8'h01;
        end
    end
    property p_restore_next; rx_error |=> rx_restore; endproperty
    a_restore_next: assert property (p_restore_next) else $error("restore missing");
    property p_restore_only; !rx_error |=> !rx_restore; endproperty
    a_restore_only: assert property (p_restore_only) else $error("stray restore");
    property p_restore_page;
        rx_page_load ##1 (rx_error && !rx_page_load) |=> rx_restore_page == $past(rx_page_value, 2);
    endproperty
    a_restore_page: assert property (p_restore_page) else $error("restore page");
    property p_oe_track; hb_data_oe == $past(rd_act, 2); endproperty
    a_oe_track: assert property (p_oe_track) else $error("data enable");
    property p_start_pulse; tx_start |=> !tx_start; endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start width");
    property p_start_cause; tx_start |-> wr_age_r <= 8'h08; endproperty
    a_start_cause: assert property (p_start_cause) else $error("start no write");
    property p_len_quiet; wr_age_r > 8'h08 |-> $stable(tx_len); endproperty
    a_len_quiet: assert property (p_len_quiet) else $error("length moved");
    property p_start_len; tx_start |-> $stable(tx_len); endproperty
    a_start_len: assert property (p_start_len) else $error("length at start");
endmodule
bind txs_regs txs_regs_props #(.LW(LW)) txs_regs_props_inst (
    .clk(clk), .rst(rst), .hb_cs_n(hb_cs_n), .hb_rd_n(hb_rd_n), .hb_wr_n(hb_wr_n),
    .hb_data_oe(hb_data_oe), .tx_start(tx_start), .tx_len(tx_len),
    .rx_page_load(rx_page_load), .rx_page_value(rx_page_value), .rx_error(rx_error),
    .rx_restore(rx_restore), .rx_restore_page(rx_restore_page)
);
`default_nettype wire

// ===== tb/txs_host.sv
// host model: drives the asynchronous register bus pins
`timescale 1ns/10ps
`default_nettype none
module txs_host import txs_pkg::*; (
    input  wire logic              clk,
    input  wire logic [DATA_W-1:0] dout,
    output logic                   cs_n,
    output logic                   rd_n,
    output logic                   wr_n,
    output logic      [ADDR_W-1:0] addr,
    output logic      [DATA_W-1:0] data
);
    initial begin
        {cs_n, rd_n, wr_n} = 3'h7;
        addr = 4'h0;
        data = 8'h00;
    end
    // strobe low 5 edges, gap 5: both clear the two-flop sync delay
    task automatic access(input logic wr, input logic [3:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge clk);
        cs_n <= 1'b0;
        rd_n <= wr;
        wr_n <= !wr;
        addr <= a;
        data <= d;
        repeat (5) @(posedge clk);
        q = dout;
        {cs_n, rd_n, wr_n} <= 3'h7;
        // released lines show the inverse so a stale value cannot pass
        data <= ~d;
        repeat (5) @(posedge clk);
    endtask
    task automatic page(input logic [1:0] p);
        logic [7:0] q;
        access(1'b1, OFS_COMMAND, {p, 6'h21}, q);
    endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// testbench: register accesses with transmit and receive events
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] %s exp %h seen %h", n, e, g); end end
module tb_top import txs_pkg::*;;
    localparam logic [5:0] A_ST = 6'h20, A_CO = 6'h10, A_DN = 6'h08;
    localparam logic [5:0] A_OK = 6'h04, A_LT = 6'h02, A_EX = 6'h01;
    logic             clk, rst, cs_n, rd_n, wr_n, oe, start, rx_load, rx_err, restore;
    logic [3:0]       addr;
    logic [7:0]       din, dout, q, rx_val, rpage;
    logic [15:0]      len;
    txs_tx_ev_s       ev;
    int               bad_count, checks, cyc, starts;

    txs_regs txs_regs_inst (.clk(clk), .rst(rst), .hb_cs_n(cs_n), .hb_rd_n(rd_n),
        .hb_wr_n(wr_n), .hb_addr(addr), .hb_data_in(din), .hb_data_out(dout),
        .hb_data_oe(oe), .tx_ev(ev), .tx_start(start), .tx_len(len),
        .rx_page_load(rx_load), .rx_page_value(rx_val), .rx_error(rx_err),
        .rx_restore(restore), .rx_restore_page(rpage));
    txs_host txs_host_inst (.clk(clk), .dout(dout), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .addr(addr), .data(din));

    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (start === 1'b1) begin
            starts++;
        end
        if (cyc == 4000) begin
            bad_count++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
        txs_host_inst.access(1'b0, a, 8'h00, q);
        `CHK(n, e, q)
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] x;
        txs_host_inst.access(1'b1, a, d, x);
    endtask
    task automatic pulse(input logic [5:0] v);
        @(posedge clk);
        ev <= v;
        @(posedge clk);
        ev <= '0;
    endtask
    task automatic send();
        int s;
        s = starts;
        wr(OFS_COMMAND, {PAGE_0, 6'h25});
        `CHK("start", s + 1, starts)
    endtask
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        ev = '0;
        {rx_load, rx_err, rx_val} = 10'h000;
        {bad_count, checks, cyc, starts} = '0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_TX_OUTCOME, TX_OUTCOME_RST, "outcome");
        rd(OFS_TX_TALLY, TX_TALLY_RST, "tally");
        txs_host_inst.page(PAGE_1);
        rd(OFS_RX_PAGE, RX_PAGE_RST, "rx page");
        txs_host_inst.page(PAGE_0);
        $display("test reset values done");
        wr(OFS_TX_LEN_HIGH, 8'h05);
        wr(OFS_TX_LEN_LOW, 8'hea);
        `CHK("length", 16'h05ea, len)
        rd(OFS_TX_TALLY, 8'h00, "tally");
        rd(OFS_TX_LEN_HIGH, READ_ZERO, "write only");
        wr(OFS_TX_OUTCOME, 8'hff);
        rd(OFS_TX_OUTCOME, 8'h00, "read only");
        $display("test length done");
        send();
        pulse(A_ST);
        pulse(A_DN | A_OK);
        rd(OFS_TX_OUTCOME, 8'h01, "outcome");
        rd(OFS_TX_TALLY, 8'h00, "tally");
        $display("test clean send done");
        send();
        pulse(A_ST);
        repeat (3) pulse(A_CO);
        rd(OFS_TX_TALLY, 8'h03, "tally");
        pulse(A_DN | A_OK);
        rd(OFS_TX_OUTCOME, 8'h05, "outcome");
        rd(OFS_TX_OUTCOME, 8'h05, "outcome hold");
        send();
        rd(OFS_TX_TALLY, 8'h00, "tally");
        rd(OFS_TX_OUTCOME, 8'h00, "outcome");
        pulse(A_ST);
        pulse(A_CO);
        pulse(A_DN | A_LT);
        rd(OFS_TX_OUTCOME, 8'h84, "outcome");
        $display("test collisions done");
        send();
        pulse(A_ST);
        repeat (16) pulse(A_CO);
        pulse(A_DN | A_EX);
        rd(OFS_TX_OUTCOME, 8'h0c, "outcome");
        rd(OFS_TX_TALLY, 8'h00, "tally");
        $display("test abort done");
        rd(OFS_COMMAND, COMMAND_RST, "command");
        txs_host_inst.page(2'h2);
        rd(OFS_TX_OUTCOME, READ_ZERO, "page 2 outcome");
        wr(OFS_TX_LEN_LOW, 8'h11);
        `CHK("length page 2", 16'h05ea, len)
        $display("test page select done");
        txs_host_inst.page(PAGE_1);
        wr(OFS_RX_PAGE, 8'h46);
        rd(OFS_RX_PAGE, 8'h46, "rx page");
        @(posedge clk);
        rx_load <= 1'b1;
        rx_val <= 8'h60;
        @(posedge clk);
        rx_load <= 1'b0;
        rx_err <= 1'b1;
        @(posedge clk);
        rx_err <= 1'b0;
        #1 `CHK("restore", 1'b1, restore)
        `CHK("restore page", 8'h60, rpage)
        @(posedge clk);
        #1 `CHK("restore end", 1'b0, restore)
        rd(OFS_RX_PAGE, 8'h60, "rx page");
        txs_host_inst.page(PAGE_0);
        $display("test receive page done");
        wrap_up();
    end
endmodule
`default_nettype wire
